// ---- inc/erff_cfg.svh ----
// Purpose: Constants of the receive frame filter: offsets, fields, resets
// Assumes: 32-bit register words, byte addresses
// Notes:   Definitions only
`ifndef ERFF_CFG_SVH
`define ERFF_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ERFF_ADDR_W          8
`define ERFF_OFF_FILTER_CFG  8'h00
`define ERFF_OFF_STA_LO      8'h04
`define ERFF_OFF_STA_HI      8'h08
`define ERFF_OFF_CTRL_ONE    8'h0C
`define ERFF_OFF_ACCEPT_CNT  8'h10
`define ERFF_OFF_DROP_CNT    8'h14
`define ERFF_OFF_STATUS      8'h18

// ----------------------------------------------------------------
// Filter configuration fields
// ----------------------------------------------------------------
`define ERFF_BIT_HASH_EN     15
`define ERFF_BIT_WAKE_EN     14
`define ERFF_BIT_PM_INV      12
`define ERFF_PM_SEL_HI       11
`define ERFF_PM_SEL_LO       8
`define ERFF_BIT_BAD_CRC     7
`define ERFF_BIT_GOOD_CRC    6
`define ERFF_BIT_SHORT_COL   5
`define ERFF_BIT_SHORT_REJ   4
`define ERFF_BIT_STA_MATCH   3
`define ERFF_BIT_FOREIGN     2
`define ERFF_BIT_GROUP       1
`define ERFF_BIT_ALL_STA     0
`define ERFF_CFG_WR_MASK     32'h0000_DFFF
`define ERFF_CFG_RESET       32'h0000_0000
`define ERFF_BIT_RX_EN       8
`define ERFF_CTRL_WR_MASK    32'h0000_0100
`define ERFF_CTRL_RESET      32'h0000_0000
`define ERFF_STA_RESET       48'h0000_0000_0000

// ----------------------------------------------------------------
// Frame limits and buffer depth
// ----------------------------------------------------------------
`define ERFF_MIN_FRAME_BYTES 16'h0040
`define ERFF_BUF_DEPTH       2'h2

`endif

// ---- inc/erff_pkg.sv ----
// Purpose: Types of the receive frame filter
// Assumes: Constants come from erff_cfg.svh
// Notes:   One frame summary in, one verdict out
package erff_pkg;

  // Summary of one received frame from the receive path
  typedef struct packed {
    logic [47:0] dest_addr;    // First octet in bits 47:40
    logic [15:0] length;       // Bytes, including CRC
    logic        crc_ok;       // Frame check sequence good
    logic        csum_match;   // Pattern checksum matched
    logic        hash_match;   // Hash table hit
    logic        wakeup_match; // Wake-up frame seen
  } erff_frame_t;

  // Verdict for one frame
  typedef struct packed {
    logic        accept;
    logic        pattern_hit;
    logic        addr_hit;
    logic        qualify_ok;
    logic        short_frame;
    logic [15:0] length;
  } erff_verdict_t;

  // Pattern match selections
  typedef enum logic [3:0] {
    ERFF_PM_OFF      = 4'h0,
    ERFF_PM_CSUM     = 4'h1,
    ERFF_PM_STA_A    = 4'h2,
    ERFF_PM_STA_B    = 4'h3,
    ERFF_PM_UNI_A    = 4'h4,
    ERFF_PM_UNI_B    = 4'h5,
    ERFF_PM_BCAST_A  = 4'h6,
    ERFF_PM_BCAST_B  = 4'h7,
    ERFF_PM_HASH     = 4'h8,
    ERFF_PM_WAKE     = 4'h9
  } erff_pm_sel_t;

endpackage

// ---- hw/erff_rx_filter.sv ----
// Purpose: Receive frame acceptance filter with register port
// Assumes: Frame summaries arrive complete, one per handshake
// Notes:   Verdicts leave through a two-entry buffer
//
// Function
// RQ1: Bad-CRC collect: accept only failed CRC frames
// RQ2: Good-CRC enable: reject every bad CRC frame
// RQ3: Short collect: accept only short frames
// RQ4: Short means under 64 bytes, plus good CRC; the code asks for good CRC only while Good-CRC enable is set
// RQ5: Short reject: drop every frame under 64
// RQ6: Accept unicast equal to station address
// RQ7: Accept unicast differing from station address
// RQ8: Accept every multicast destination when enabled
// RQ9: Accept broadcast destination when enabled
// RQ10: Hash pattern mode ignores hash enable
// RQ11: Wake-up pattern mode ignores wake-up enable
// RQ12: Checksum match XOR pattern inversion
// RQ13: Configuration affects receive path only
// RQ14: Software changes config only while receive off
// RQ15: Pattern select zero: match always fails
// RQ16: Accept: some address path and all qualifiers
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "erff_cfg.svh"

module erff_rx_filter
  import erff_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Register port
  input  wire logic [`ERFF_ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  // Frame summaries from the receive path
  input  wire logic                      frm_valid,
  input  wire erff_frame_t               frm_data,
  output logic                           frm_ready,
  // Verdicts toward the receive buffer manager
  output logic                           vrd_valid,
  output erff_verdict_t                  vrd_data,
  input  wire logic                      vrd_ready,
  // Receive enable level for the receive path
  output logic                           rx_enabled
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Group bit of the first destination octet
  function automatic logic is_group(input logic [47:0] da);
    is_group = da[40];
  endfunction

  // All-ones destination
  function automatic logic is_bcast(input logic [47:0] da);
    is_bcast = &da;
  endfunction

  // Saturating increment of a frame counter
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (&v) ? v : v + 32'h0000_0001;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0]   cfg_q;
  logic [31:0]   ctrl_q;
  logic [47:0]   sta_q;
  logic [31:0]   acc_cnt_q;
  logic [31:0]   drop_cnt_q;
  logic [31:0]   rdata_d;
  logic [31:0]   rdata_q;
  logic          rx_en_q;

  // Buffer storage and flags
  erff_verdict_t head_q;
  erff_verdict_t tail_q;
  logic [1:0]    cnt_q;
  logic [1:0]    cnt_d;
  logic          in_ready_q;
  logic          take;
  logic          pop;

  // Field views of the configuration
  logic          hash_filter_en;
  logic          wakeup_frame_filter_en;
  logic          pattern_invert;
  logic [3:0]    pattern_match_select;
  logic          bad_crc_collect_en;
  logic          good_crc_required_en;
  logic          short_frame_collect_en;
  logic          short_frame_reject_en;
  logic          station_match_accept_en;
  logic          foreign_unicast_accept_en;
  logic          group_addr_accept_en;
  logic          all_stations_accept_en;

  // Classification of the offered frame
  logic          f_group;
  logic          f_bcast;
  logic          f_mcast;
  logic          f_unicast;
  logic          f_sta_hit;
  logic          f_short;
  logic          f_short_col;
  logic          csum_term;
  logic          pm_hit;
  logic          addr_hit;
  logic          qual_ok;
  erff_verdict_t verdict;

  // Configuration field taps
  assign hash_filter_en            = cfg_q[`ERFF_BIT_HASH_EN];
  assign wakeup_frame_filter_en    = cfg_q[`ERFF_BIT_WAKE_EN];
  assign pattern_invert            = cfg_q[`ERFF_BIT_PM_INV];
  assign pattern_match_select      = cfg_q[`ERFF_PM_SEL_HI:`ERFF_PM_SEL_LO];
  assign bad_crc_collect_en        = cfg_q[`ERFF_BIT_BAD_CRC];
  assign good_crc_required_en      = cfg_q[`ERFF_BIT_GOOD_CRC];
  assign short_frame_collect_en    = cfg_q[`ERFF_BIT_SHORT_COL];
  assign short_frame_reject_en     = cfg_q[`ERFF_BIT_SHORT_REJ];
  assign station_match_accept_en   = cfg_q[`ERFF_BIT_STA_MATCH];
  assign foreign_unicast_accept_en = cfg_q[`ERFF_BIT_FOREIGN];
  assign group_addr_accept_en      = cfg_q[`ERFF_BIT_GROUP];
  assign all_stations_accept_en    = cfg_q[`ERFF_BIT_ALL_STA];

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------

  // Filter configuration; the receive path alone acts on it, the read mux returns it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `ERFF_CFG_RESET;
    end else if (reg_wr && reg_addr == `ERFF_OFF_FILTER_CFG) begin
      cfg_q <= reg_wdata & `ERFF_CFG_WR_MASK; // RQ13
    end
  end

  // Control word holding the receive enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `ERFF_CTRL_RESET;
    end else if (reg_wr && reg_addr == `ERFF_OFF_CTRL_ONE) begin
      ctrl_q <= reg_wdata & `ERFF_CTRL_WR_MASK;
    end
  end

  // Station address, low four octets then high two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sta_q <= `ERFF_STA_RESET;
    end else if (reg_wr && reg_addr == `ERFF_OFF_STA_LO) begin
      sta_q[31:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == `ERFF_OFF_STA_HI) begin
      sta_q[47:32] <= reg_wdata[15:0];
    end
  end

  // Registered receive enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_en_q <= 1'b0;
    end else begin
      rx_en_q <= ctrl_q[`ERFF_BIT_RX_EN];
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (reg_addr)
      `ERFF_OFF_FILTER_CFG: rdata_d = cfg_q;
      `ERFF_OFF_STA_LO:     rdata_d = sta_q[31:0];
      `ERFF_OFF_STA_HI:     rdata_d = {16'h0000, sta_q[47:32]};
      `ERFF_OFF_CTRL_ONE:   rdata_d = ctrl_q;
      `ERFF_OFF_ACCEPT_CNT: rdata_d = acc_cnt_q;
      `ERFF_OFF_DROP_CNT:   rdata_d = drop_cnt_q;
      `ERFF_OFF_STATUS:     rdata_d = {28'h000_0000, in_ready_q, vrd_valid, cnt_q};
      default:              rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data stand one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Frame classification
  // ----------------------------------------------------------------

  // Destination address kinds
  assign f_group   = is_group(frm_data.dest_addr);
  assign f_bcast   = is_bcast(frm_data.dest_addr);
  assign f_mcast   = f_group && !f_bcast;
  assign f_unicast = !f_group;
  assign f_sta_hit = f_unicast && (frm_data.dest_addr == sta_q);

  // Short frame tests
  assign f_short     = frm_data.length < `ERFF_MIN_FRAME_BYTES; // RQ4
  assign f_short_col = f_short && (!good_crc_required_en || frm_data.crc_ok); // RQ4

  // Checksum term with inversion
  assign csum_term = pattern_invert ^ frm_data.csum_match; // RQ12

  // Pattern match by selection
  always_comb begin
    pm_hit = 1'b0;
    case (pattern_match_select)
      ERFF_PM_OFF:     pm_hit = 1'b0; // RQ15
      ERFF_PM_CSUM:    pm_hit = csum_term;
      ERFF_PM_STA_A,
      ERFF_PM_STA_B:   pm_hit = csum_term && f_sta_hit;
      ERFF_PM_UNI_A,
      ERFF_PM_UNI_B:   pm_hit = csum_term && f_unicast;
      ERFF_PM_BCAST_A,
      ERFF_PM_BCAST_B: pm_hit = csum_term && f_bcast;
      ERFF_PM_HASH:    pm_hit = csum_term && frm_data.hash_match; // RQ10
      ERFF_PM_WAKE:    pm_hit = csum_term && frm_data.wakeup_match; // RQ11
      default:         pm_hit = 1'b0;
    endcase
  end

  // Address acceptance paths, any one suffices
  always_comb begin
    addr_hit = 1'b0;
    if (station_match_accept_en && f_sta_hit) begin
      addr_hit = 1'b1; // RQ6
    end
    if (foreign_unicast_accept_en && f_unicast && !f_sta_hit) begin
      addr_hit = 1'b1; // RQ7
    end
    if (group_addr_accept_en && f_mcast) begin
      addr_hit = 1'b1; // RQ8
    end
    if (all_stations_accept_en && f_bcast) begin
      addr_hit = 1'b1; // RQ9
    end
    if (hash_filter_en && frm_data.hash_match) begin
      addr_hit = 1'b1;
    end
    if (wakeup_frame_filter_en && frm_data.wakeup_match) begin
      addr_hit = 1'b1;
    end
    if (pm_hit) begin
      addr_hit = 1'b1;
    end
  end

  // Qualifiers, every enabled one must hold
  always_comb begin
    qual_ok = 1'b1;
    if (bad_crc_collect_en && frm_data.crc_ok) begin
      qual_ok = 1'b0; // RQ1
    end
    if (good_crc_required_en && !frm_data.crc_ok) begin
      qual_ok = 1'b0; // RQ2
    end
    if (short_frame_collect_en && !f_short_col) begin
      qual_ok = 1'b0; // RQ3
    end
    if (short_frame_reject_en && f_short) begin
      qual_ok = 1'b0; // RQ5
    end
  end

  // Verdict for the offered frame
  always_comb begin
    verdict             = '0;
    verdict.accept      = addr_hit && qual_ok; // RQ16
    verdict.pattern_hit = pm_hit;
    verdict.addr_hit    = addr_hit;
    verdict.qualify_ok  = qual_ok;
    verdict.short_frame = f_short;
    verdict.length      = frm_data.length;
  end

  // ----------------------------------------------------------------
  // Two-entry verdict buffer
  // ----------------------------------------------------------------

  // Handshakes on both sides
  assign take = frm_valid && in_ready_q;
  assign pop  = vrd_valid && vrd_ready;

  // Occupancy after this cycle
  always_comb begin
    cnt_d = cnt_q;
    if (take && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !take) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  // Occupancy and output valid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= 2'h0;
      vrd_valid <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      vrd_valid <= cnt_d != 2'h0;
    end
  end

  // Head feeds the output, tail holds the second entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_q <= '0;
      tail_q <= '0;
    end else begin
      case (cnt_q)
        2'h0: begin
          if (take) begin
            head_q <= verdict;
          end
        end
        2'h1: begin
          if (take && pop) begin
            head_q <= verdict;
          end else if (take) begin
            tail_q <= verdict;
          end
        end
        default: begin
          if (pop) begin
            head_q <= tail_q;
          end
        end
      endcase
    end
  end

  // Ready only with room and receive enabled; stall holds the source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_ready_q <= 1'b0;
    end else begin
      in_ready_q <= ctrl_q[`ERFF_BIT_RX_EN] && (cnt_d < `ERFF_BUF_DEPTH);
    end
  end

  // ----------------------------------------------------------------
  // Frame statistics
  // ----------------------------------------------------------------

  // Accepted and dropped counts, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_cnt_q  <= 32'h0000_0000;
      drop_cnt_q <= 32'h0000_0000;
    end else if (take) begin
      if (verdict.accept) begin
        acc_cnt_q <= sat_inc(acc_cnt_q);
      end else begin
        drop_cnt_q <= sat_inc(drop_cnt_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata  = rdata_q;
  assign frm_ready  = in_ready_q;
  assign vrd_data   = head_q;
  assign rx_enabled = rx_en_q;

endmodule

// ---- testbench/erff_rx_monitor.sv ----
// Purpose: Port assertions for the receive frame filter
// Assumes: Filter config written only while receive is off
// Notes:   Bound to erff_rx_filter
`timescale 1ns/1ps
`include "erff_cfg.svh"

module erff_rx_monitor
  import erff_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic [`ERFF_ADDR_W-1:0] reg_addr,
  input wire logic [31:0]             reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [31:0]             reg_rdata,
  input wire logic                    frm_valid,
  input wire erff_frame_t             frm_data,
  input wire logic                    frm_ready,
  input wire logic                    vrd_valid,
  input wire erff_verdict_t           vrd_data,
  input wire logic                    vrd_ready,
  input wire logic                    rx_enabled
);
  // ----------------------------------------------------------------
  // Shadow configuration
  // ----------------------------------------------------------------
  logic [31:0] cfg_q;
  logic        take;

  // Frame taken into an empty buffer
  assign take = frm_valid && frm_ready && !vrd_valid;

  // Mirror of the filter configuration writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= 32'h0000_0000;
    end else if (reg_wr && reg_addr == `ERFF_OFF_FILTER_CFG) begin
      cfg_q <= reg_wdata & `ERFF_CFG_WR_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_BAD_CRC: assert property (take && cfg_q[7] && frm_data.crc_ok |=> !vrd_data.accept)
    else $error("good CRC frame kept in collect mode");
  AST_GOOD_CRC: assert property (take && cfg_q[6] && !frm_data.crc_ok |=> !vrd_data.accept)
    else $error("bad CRC frame kept");
  AST_SHORT_COL: assert property (vrd_valid && cfg_q[5]
    && vrd_data.length >= 16'h0040 |-> !vrd_data.accept)
    else $error("long frame kept in short collect mode");
  AST_SHORT_REJ: assert property (vrd_valid && cfg_q[4]
    && vrd_data.length < 16'h0040 |-> !vrd_data.accept)
    else $error("short frame kept");
  AST_BCAST: assert property (take && cfg_q[15:0] == 16'h0001
    && (&frm_data.dest_addr) |=> vrd_data.accept)
    else $error("broadcast frame dropped");
  AST_PM_OFF: assert property (vrd_valid && cfg_q[11:8] == 4'h0 |-> !vrd_data.pattern_hit)
    else $error("pattern hit with matching off");
  AST_NO_ADDR: assert property (vrd_valid && !vrd_data.addr_hit
    && !vrd_data.pattern_hit |-> !vrd_data.accept)
    else $error("frame kept without address path");
  AST_ANSWER: assert property (take |=> vrd_valid
    && vrd_data.length == $past(frm_data.length))
    else $error("verdict missing or wrong length");
  AST_HOLD: assert property (vrd_valid && !vrd_ready |=> vrd_valid && $stable(vrd_data))
    else $error("verdict changed while stalled");
endmodule

bind erff_rx_filter erff_rx_monitor erff_rx_monitor_i (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frm_valid(frm_valid), .frm_data(frm_data),
  .frm_ready(frm_ready), .vrd_valid(vrd_valid), .vrd_data(vrd_data),
  .vrd_ready(vrd_ready), .rx_enabled(rx_enabled));

// ---- testbench/erff_phy_model.sv ----
// Purpose: Receive path model offering frame summaries
// Assumes: Summaries queued by the bench through push
// Notes:   Idle data toggles so stale values never look valid
`timescale 1ns/1ps

module erff_phy_model
  import erff_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  output logic       frm_valid,
  output erff_frame_t frm_data,
  input  wire logic  frm_ready
);
  erff_frame_t fq[$];

  task automatic push(input erff_frame_t f);
    fq.push_back(f);
  endtask

  // Offer the next summary, hold it until taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frm_valid <= 1'b0;
      frm_data  <= '0;
    end else if (!frm_valid || frm_ready) begin
      if (fq.size() > 0) begin
        frm_valid <= 1'b1;
        frm_data  <= fq.pop_front();
      end else begin
        frm_valid <= 1'b0;
        frm_data  <= ~frm_data; // Released: changes every cycle
      end
    end
  end
endmodule

// ---- testbench/tb_ethernet_rx_frame_filter.sv ----
// Purpose: Self-checking bench of the receive frame filter
// Assumes: 125 MHz clock, active-low async reset
// Notes:   Each scenario is its own task
`timescale 1ns/1ps
`include "erff_cfg.svh"

module tb_ethernet_rx_frame_filter
  import erff_pkg::*;
  ;
  logic          clk, rst_n, reg_wr, reg_rd, frm_valid, frm_ready;
  logic          vrd_valid, vrd_ready, rx_enabled;
  logic [7:0]    reg_addr;
  logic [31:0]   reg_wdata, reg_rdata;
  erff_frame_t   frm_data;
  erff_verdict_t vrd_data;
  erff_verdict_t vq[$];
  int            mismatches, comparisons, acc, tot;
  logic [47:0]   dests [4] = '{48'h1022_3344_5566, 48'h1022_3344_5567,
                               48'h0100_5E00_0001, 48'hFFFF_FFFF_FFFF};

  erff_rx_filter erff_rx_filter_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frm_valid(frm_valid), .frm_data(frm_data),
    .frm_ready(frm_ready), .vrd_valid(vrd_valid), .vrd_data(vrd_data),
    .vrd_ready(vrd_ready), .rx_enabled(rx_enabled));
  erff_phy_model erff_phy_model_i (
    .clk(clk), .rst_n(rst_n), .frm_valid(frm_valid), .frm_data(frm_data),
    .frm_ready(frm_ready));

  // ----------------------------------------------------------------
  // Clock, verdict capture, helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Collect popped verdicts
  always @(posedge clk) begin
    if (vrd_valid && vrd_ready) vq.push_back(vrd_data);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  task automatic get_vrd(output erff_verdict_t v);
    int n;
    for (n = 0; n < 60 && vq.size() == 0; n++) @(posedge clk);
    #1 check(32'(vq.size() > 0), 32'h1);
    v = (vq.size() > 0) ? vq.pop_front() : '0;
  endtask

  // Filter setup with receive off, then receive on
  task automatic setup(input logic [15:0] cfg);
    reg_write(`ERFF_OFF_CTRL_ONE, 32'h0000_0000);
    reg_write(`ERFF_OFF_FILTER_CFG, {16'h0000, cfg});
    reg_write(`ERFF_OFF_CTRL_ONE, 32'h0000_0100);
  endtask

  task automatic send(input logic [1:0] d, input logic [15:0] len, input logic [3:0] fl);
    erff_phy_model_i.push({dests[d], len, fl});
    tot++;
  endtask

  task automatic run_case(input logic [15:0] cfg, input logic [1:0] d, input logic [7:0] len,
                          input logic [3:0] fl, input logic ex);
    erff_verdict_t v;
    setup(cfg);
    send(d, {8'h00, len}, fl);
    get_vrd(v);
    check(v.accept, ex);
    check({v.short_frame, v.length}, {len < 8'h40, 8'h00, len});
    acc += ex;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd_chk(`ERFF_OFF_FILTER_CFG, 32'h0000_0000);
    rd_chk(`ERFF_OFF_CTRL_ONE, 32'h0000_0000);
    reg_write(`ERFF_OFF_FILTER_CFG, 32'hFFFF_FFFF);
    rd_chk(`ERFF_OFF_FILTER_CFG, 32'h0000_DFFF);
    reg_write(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0000_0000);
    reg_write(`ERFF_OFF_STA_LO, 32'h3344_5566);
    reg_write(`ERFF_OFF_STA_HI, 32'h0000_1022);
    rd_chk(`ERFF_OFF_STA_HI, 32'h0000_1022);
    $display("test regs done");
  endtask

  task automatic t_table();
    run_case(16'h0008, 2'h0, 8'h64, 4'h8, 1'b1);
    run_case(16'h0008, 2'h1, 8'h64, 4'h8, 1'b0);
    run_case(16'h0004, 2'h1, 8'h64, 4'h8, 1'b1);
    run_case(16'h0004, 2'h0, 8'h64, 4'h8, 1'b0);
    run_case(16'h0002, 2'h2, 8'h64, 4'h8, 1'b1);
    run_case(16'h0002, 2'h1, 8'h64, 4'h8, 1'b0);
    run_case(16'h0001, 2'h3, 8'h64, 4'h8, 1'b1);
    run_case(16'h0000, 2'h3, 8'h64, 4'h8, 1'b0);
    run_case(16'h0041, 2'h3, 8'h64, 4'h0, 1'b0);
    run_case(16'h0041, 2'h3, 8'h64, 4'h8, 1'b1);
    run_case(16'h0081, 2'h3, 8'h64, 4'h8, 1'b0);
    run_case(16'h0081, 2'h3, 8'h64, 4'h0, 1'b1);
    run_case(16'h0021, 2'h3, 8'h3F, 4'h0, 1'b1);
    run_case(16'h0021, 2'h3, 8'h40, 4'h8, 1'b0);
    run_case(16'h0061, 2'h3, 8'h3F, 4'h8, 1'b1);
    run_case(16'h0011, 2'h3, 8'h3F, 4'h8, 1'b0);
    run_case(16'h0011, 2'h3, 8'h40, 4'h8, 1'b1);
    run_case(16'h0100, 2'h1, 8'h64, 4'hC, 1'b1);
    run_case(16'h1100, 2'h1, 8'h64, 4'hC, 1'b0);
    run_case(16'h1100, 2'h1, 8'h64, 4'h8, 1'b1);
    run_case(16'h0800, 2'h1, 8'h64, 4'hE, 1'b1);
    run_case(16'h0800, 2'h1, 8'h64, 4'hC, 1'b0);
    run_case(16'h0900, 2'h1, 8'h64, 4'hD, 1'b1);
    run_case(16'h8000, 2'h1, 8'h64, 4'hA, 1'b1);
    run_case(16'h4000, 2'h1, 8'h64, 4'h9, 1'b1);
    run_case(16'h0200, 2'h0, 8'h64, 4'hC, 1'b1);
    run_case(16'h0300, 2'h1, 8'h64, 4'hC, 1'b0);
    run_case(16'h0400, 2'h1, 8'h64, 4'hC, 1'b1);
    run_case(16'h0500, 2'h2, 8'h64, 4'hC, 1'b0);
    run_case(16'h0600, 2'h3, 8'h64, 4'hC, 1'b1);
    run_case(16'h0700, 2'h2, 8'h64, 4'hC, 1'b0);
    run_case(16'h0A00, 2'h1, 8'h64, 4'hF, 1'b0);
    run_case(16'h0000, 2'h1, 8'h64, 4'hC, 1'b0);
    $display("test table done");
  endtask

  task automatic t_rx_off();
    erff_verdict_t v;
    setup(16'h0001);
    reg_write(`ERFF_OFF_CTRL_ONE, 32'h0000_0000);
    @(posedge clk);
    send(2'h3, 16'h0080, 4'h8);
    repeat (10) @(posedge clk);
    #1 check({rx_enabled, frm_ready, 30'(vq.size())}, 32'h0);
    reg_write(`ERFF_OFF_CTRL_ONE, 32'h0000_0100);
    get_vrd(v);
    check(v.length, 32'h0080);
    check({rx_enabled, v.accept}, 32'h3);
    acc++;
    $display("test rx_off done");
  endtask

  task automatic t_stall();
    erff_verdict_t v;
    @(posedge clk);
    vrd_ready <= 1'b0;
    for (int i = 0; i < 3; i++) send(2'h3, 16'h0100 + 16'(i), 4'h8);
    repeat (10) @(posedge clk);
    #1 check({frm_ready, 31'(vq.size())}, 32'h0);
    rd_chk(`ERFF_OFF_STATUS, 32'h0000_0006);
    @(posedge clk);
    vrd_ready <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      get_vrd(v);
      check({v.accept, v.length}, {1'b1, 16'h0100 + 16'(i)});
    end
    acc += 3;
    $display("test stall done");
  endtask

  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog: far beyond the expected run of about 400 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end

  // Main sequence
  initial begin
    rst_n     = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    vrd_ready = 1'b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_table();
    t_rx_off();
    t_stall();
    rd_chk(`ERFF_OFF_ACCEPT_CNT, 32'(acc));
    rd_chk(`ERFF_OFF_DROP_CNT, 32'(tot - acc));
    final_report();
  end
endmodule
